// file: pkg/mpt_pkg.sv
package mpt_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_RUN = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_FFCTL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_LIVE = 8'h14;
  localparam logic [7:0] OFS_CMP0 = 8'h20;
  localparam logic [7:0] OFS_CMP1 = 8'h24;
  localparam logic [7:0] OFS_CAP0 = 8'h28;
  localparam logic [7:0] OFS_CAP1 = 8'h2C;
  localparam logic [7:0] OFS_PAIR_CTL = 8'h30;
  localparam logic [7:0] OFS_PAIR_RST = 8'h34;
  localparam logic [7:0] OFS_PAIR_ST = 8'h38;
  localparam logic [7:0] OFS_PAIR_ICTL = 8'h3C;
  localparam logic [7:0] OFS_PAIR_OCTL = 8'h40;
  localparam logic [7:0] OFS_PAIR_CMP2 = 8'h44;
  localparam logic [7:0] OFS_PAIR_CMP3 = 8'h48;
  localparam logic [7:0] OFS_PAIR_PER = 8'h4C;
  localparam logic [7:0] OFS_EMG_CTL = 8'h50;
  localparam logic [7:0] OFS_EMG_ST = 8'h54;
  localparam logic [7:0] OFS_PAIR_TRG = 8'h58;
  // ==========================================================
  // Field positions
  localparam int EN_GATE_BIT = 7;
  localparam int EN_HALT_BIT = 6;
  localparam int EN_MODE_BIT = 0;
  localparam int RUN_PRESC_BIT = 2;
  localparam int RUN_COUNT_BIT = 0;
  localparam int MODE_CLK_LSB = 0;
  localparam int MODE_CLE_BIT = 2;
  localparam int MODE_PCM_LSB = 3;
  localparam int MODE_SWCAP_BIT = 5;
  localparam int MODE_WBF_BIT = 6;
  localparam int FF_CTL_LSB = 0;
  localparam int FF_TE0_BIT = 2;
  localparam int FF_TE1_BIT = 3;
  localparam int FF_TC0_BIT = 4;
  localparam int FF_TC1_BIT = 5;
  localparam int EMG_OC_LSB = 1;
  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [2:0] RUN_RST = 3'h0;
  localparam logic [6:0] MODE_RST = 7'h20;
  localparam logic [5:0] FFCTL_RST = 6'h03;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] FF_TOGGLE = 2'h0;
  localparam logic [1:0] FF_SET = 2'h1;
  localparam logic [1:0] FF_CLEAR = 2'h2;
  localparam logic [1:0] CAP_NONE = 2'h0;
  localparam logic [1:0] CAP_PIN_RISE = 2'h1;
  localparam logic [1:0] CAP_PIN_BOTH = 2'h2;
  localparam logic [1:0] CAP_FF_EDGE = 2'h3;
  localparam logic [3:0] PRESC_RST = 4'h0;
endpackage

// file: pkg/mpt_cmp_if.sv
`timescale 1ns/1ns
interface mpt_cmp_if;
  logic [15:0] count;
  logic [15:0] cmp0;
  logic [15:0] cmp1;
  logic match0;
  logic match1;
  modport ctl (output count, output cmp0, output cmp1, input match0, input match1);
  modport cmp (input count, input cmp0, input cmp1, output match0, output match1);
endinterface

// file: hw/mpt_comparators.sv
`timescale 1ns/1ns
module mpt_comparators
  import mpt_pkg::*;
(
  mpt_cmp_if.cmp cmp_bus
);
  // ==========================================================
  // Comparators
  assign cmp_bus.match0 = (cmp_bus.count == cmp_bus.cmp0);
  assign cmp_bus.match1 = (cmp_bus.count == cmp_bus.cmp1);
endmodule

// file: hw/mpt_channel.sv
`timescale 1ns/1ns
module mpt_channel
  import mpt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic debug_halt_i,
  input wire logic ext_clk_i,
  input wire logic capture_pin_i,
  output logic timer_output_pin_o,
  output logic first_pair_output_o,
  output logic second_pair_output_o,
  output logic overflow_irq_o,
  output logic first_match_irq_o,
  output logic second_match_irq_o,
  output logic first_capture_irq_o,
  output logic second_capture_irq_o
);
  // ==========================================================
  // Control registers
  logic [7:0] channel_enable;
  logic [2:0] run_control;
  logic [6:0] mode_reg;
  logic [5:0] ff_ctl;
  logic [31:0] pair_ctl;
  logic [31:0] pair_ictl;
  logic [31:0] pair_octl;
  logic [15:0] pair_cmp2;
  logic [15:0] pair_cmp3;
  logic [15:0] pair_per;
  logic [31:0] emg_ctl;
  logic [31:0] pair_trg;
  logic [15:0] up_counter;
  logic [15:0] compare_first;
  logic [15:0] compare_second;
  logic [15:0] buffer_first;
  logic [15:0] buffer_second;
  logic [15:0] capture_first;
  logic [15:0] capture_second;
  logic [15:0] live_count_snapshot;
  logic [3:0] prescaler;
  logic [2:0] ext_sync;
  logic [2:0] cap_sync;
  logic [2:0] status;
  logic output_toggle_flop;
  logic [1:0] count_clock_select;
  logic clear_on_match_enable;
  logic [1:0] capture_timing_select;
  logic compare_buffer_enable;
  logic [1:0] toggle_flop_control;
  logic channel_gate;
  logic debug_halt_stop;
  logic mode_select;
  logic count_run;
  logic prescaler_run;
  logic halted;
  logic tick;
  logic match0_ev;
  logic match1_ev;
  logic ovf_ev;
  logic hw_cap0;
  logic hw_cap1;
  logic cap0_ev;
  logic cap1_ev;
  logic sw_cap;
  logic acc_ok;
  logic [3:0] next_prescaler;
  logic [31:0] next_rdata;
  mpt_cmp_if cmp_bus ();

  assign channel_gate = channel_enable[EN_GATE_BIT];
  assign debug_halt_stop = channel_enable[EN_HALT_BIT];
  assign mode_select = channel_enable[EN_MODE_BIT];
  assign count_run = run_control[RUN_COUNT_BIT];
  assign prescaler_run = run_control[RUN_PRESC_BIT];
  assign count_clock_select = mode_reg[MODE_CLK_LSB +: 2];
  assign clear_on_match_enable = mode_reg[MODE_CLE_BIT];
  assign capture_timing_select = mode_reg[MODE_PCM_LSB +: 2];
  assign compare_buffer_enable = mode_reg[MODE_WBF_BIT];
  assign toggle_flop_control = ff_ctl[FF_CTL_LSB +: 2];

  // Gated-off channel: only the enable register answers
  assign acc_ok = channel_gate || (addr_i == OFS_ENABLE);
  // Gated or halted channel freezes; settings are retained
  assign halted = !channel_gate || (debug_halt_stop && debug_halt_i);

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync <= 3'h0;
      cap_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_clk_i};
      cap_sync <= {cap_sync[1:0], capture_pin_i};
    end
  end

  // ==========================================================
  // Prescaler and tick select
  always_comb begin
    next_prescaler = prescaler;
    if (!prescaler_run) begin
      next_prescaler = PRESC_RST;
    end else if (!halted) begin
      next_prescaler = prescaler + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescaler <= PRESC_RST;
    end else begin
      prescaler <= next_prescaler;
    end
  end

  always_comb begin
    unique case (count_clock_select)
      2'h0: tick = prescaler_run;
      2'h1: tick = prescaler_run && (prescaler[1:0] == 2'h3);
      2'h2: tick = prescaler_run && (prescaler == 4'hF);
      default: tick = ext_sync[1] && !ext_sync[2];
    endcase
  end

  // ==========================================================
  // Comparators and events
  assign cmp_bus.count = up_counter;
  assign cmp_bus.cmp0 = compare_first;
  assign cmp_bus.cmp1 = compare_second;

  mpt_comparators u_cmp (
    .cmp_bus(cmp_bus)
  );

  // Events count only on a counting tick so a match fires once
  assign match0_ev = count_run && !halted && tick && cmp_bus.match0;
  assign match1_ev = count_run && !halted && tick && cmp_bus.match1;
  assign ovf_ev = count_run && !halted && tick && (up_counter == CNT_MAX)
    && !(clear_on_match_enable && cmp_bus.match1);

  // ==========================================================
  // Up-counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_counter <= 16'h0000;
    end else if (!count_run) begin
      up_counter <= 16'h0000;
    end else if (!halted && tick) begin
      if (clear_on_match_enable && cmp_bus.match1) begin
        up_counter <= 16'h0000;
      end else begin
        up_counter <= up_counter + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Capture events
  assign sw_cap = wr_i && acc_ok && (addr_i == OFS_MODE) && !wdata_i[MODE_SWCAP_BIT];

  always_comb begin
    hw_cap0 = 1'b0;
    hw_cap1 = 1'b0;
    unique case (capture_timing_select)
      CAP_NONE: begin
        hw_cap0 = 1'b0;
      end
      CAP_PIN_RISE: begin
        hw_cap0 = cap_sync[1] && !cap_sync[2];
      end
      CAP_PIN_BOTH: begin
        hw_cap0 = cap_sync[1] && !cap_sync[2];
        hw_cap1 = !cap_sync[1] && cap_sync[2];
      end
      default: begin
        hw_cap0 = match0_ev;
        hw_cap1 = match1_ev;
      end
    endcase
  end

  assign cap0_ev = !halted && (hw_cap0 || sw_cap);
  assign cap1_ev = !halted && hw_cap1;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_first <= 16'h0000;
      capture_second <= 16'h0000;
    end else begin
      if (cap0_ev) begin
        capture_first <= up_counter;
      end
      if (cap1_ev) begin
        capture_second <= up_counter;
      end
    end
  end

  // ==========================================================
  // Compare registers with buffers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_first <= 16'h0000;
      compare_second <= 16'h0000;
      buffer_first <= 16'h0000;
      buffer_second <= 16'h0000;
    end else begin
      if (wr_i && acc_ok && addr_i == OFS_CMP0) begin
        buffer_first <= wdata_i[15:0];
      end
      if (wr_i && acc_ok && addr_i == OFS_CMP1) begin
        buffer_second <= wdata_i[15:0];
      end
      if (compare_buffer_enable) begin
        if (match1_ev) begin
          compare_first <= buffer_first;
          compare_second <= buffer_second;
        end
      end else begin
        if (wr_i && acc_ok && addr_i == OFS_CMP0) begin
          compare_first <= wdata_i[15:0];
        end
        if (wr_i && acc_ok && addr_i == OFS_CMP1) begin
          compare_second <= wdata_i[15:0];
        end
      end
    end
  end

  // ==========================================================
  // Control register writes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_enable <= ENABLE_RST;
      run_control <= RUN_RST;
      mode_reg <= MODE_RST;
      ff_ctl <= FFCTL_RST;
      pair_ctl <= 32'h0000_0000;
      pair_ictl <= 32'h0000_0000;
      pair_octl <= 32'h0000_0000;
      pair_cmp2 <= 16'h0000;
      pair_cmp3 <= 16'h0000;
      pair_per <= 16'h0000;
      emg_ctl <= 32'h0000_0000;
      pair_trg <= 32'h0000_0000;
    end else if (wr_i && acc_ok) begin
      unique case (addr_i)
        OFS_ENABLE: channel_enable <= {wdata_i[7:6], 5'h00, wdata_i[0]};
        OFS_RUN: run_control <= {wdata_i[2], 1'b0, wdata_i[0]};
        OFS_MODE: mode_reg <= wdata_i[6:0];
        OFS_FFCTL: ff_ctl <= wdata_i[5:0];
        OFS_PAIR_CTL: pair_ctl <= {21'h0, wdata_i[10:0]};
        OFS_PAIR_ICTL: pair_ictl <= {24'h0, wdata_i[7:6], 2'h0, wdata_i[3:0]};
        OFS_PAIR_OCTL: pair_octl <= {26'h0, wdata_i[5:4], 2'h0, wdata_i[1:0]};
        OFS_PAIR_CMP2: pair_cmp2 <= wdata_i[15:0];
        OFS_PAIR_CMP3: pair_cmp3 <= wdata_i[15:0];
        OFS_PAIR_PER: pair_per <= wdata_i[15:0];
        OFS_EMG_CTL: emg_ctl <= {24'h0, wdata_i[7:0]};
        OFS_PAIR_TRG: pair_trg <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Live snapshot and sticky status
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live_count_snapshot <= 16'h0000;
    end else if (rd_i && acc_ok && addr_i == OFS_LIVE && count_run) begin
      live_count_snapshot <= up_counter;
    end
  end

  // Status read clears; a new event in the same cycle wins
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= 3'h0;
    end else begin
      status <= ((rd_i && acc_ok && addr_i == OFS_STATUS) ? 3'h0 : status)
        | {ovf_ev, match1_ev, match0_ev};
    end
  end

  // ==========================================================
  // Toggle flop and pair outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_toggle_flop <= 1'b0;
    end else if (toggle_flop_control == FF_SET) begin
      output_toggle_flop <= 1'b1;
    end else if (toggle_flop_control == FF_CLEAR) begin
      output_toggle_flop <= 1'b0;
    end else if (toggle_flop_control == FF_TOGGLE) begin
      if ((match0_ev && ff_ctl[FF_TE0_BIT]) || (match1_ev && ff_ctl[FF_TE1_BIT])
          || (cap0_ev && ff_ctl[FF_TC0_BIT]) || (cap1_ev && ff_ctl[FF_TC1_BIT])) begin
        output_toggle_flop <= !output_toggle_flop;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_output_pin_o <= 1'b0;
      first_pair_output_o <= 1'b0;
      second_pair_output_o <= 1'b0;
    end else begin
      timer_output_pin_o <= output_toggle_flop && !mode_select;
      if (!mode_select) begin
        first_pair_output_o <= 1'b0;
        second_pair_output_o <= 1'b0;
      end else if (debug_halt_stop && debug_halt_i) begin
        first_pair_output_o <= emg_ctl[EMG_OC_LSB];
        second_pair_output_o <= emg_ctl[EMG_OC_LSB];
      end else begin
        if (match0_ev) begin
          first_pair_output_o <= 1'b1;
        end else if (match1_ev) begin
          first_pair_output_o <= 1'b0;
        end
        second_pair_output_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Event pulses
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_irq_o <= 1'b0;
      first_match_irq_o <= 1'b0;
      second_match_irq_o <= 1'b0;
      first_capture_irq_o <= 1'b0;
      second_capture_irq_o <= 1'b0;
    end else begin
      overflow_irq_o <= ovf_ev;
      first_match_irq_o <= match0_ev;
      second_match_irq_o <= match1_ev;
      first_capture_irq_o <= cap0_ev;
      second_capture_irq_o <= cap1_ev;
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i && acc_ok) begin
      unique case (addr_i)
        OFS_ENABLE: next_rdata = {24'h0, channel_enable};
        OFS_RUN: next_rdata = {29'h0, run_control};
        OFS_MODE: next_rdata = {25'h0, mode_reg};
        OFS_FFCTL: next_rdata = {26'h0, ff_ctl};
        OFS_STATUS: next_rdata = {29'h0, status};
        OFS_LIVE: next_rdata = {16'h0, count_run ? up_counter : live_count_snapshot};
        OFS_CMP0: next_rdata = {16'h0, compare_buffer_enable ? buffer_first : compare_first};
        OFS_CMP1: next_rdata = {16'h0, compare_buffer_enable ? buffer_second : compare_second};
        OFS_CAP0: next_rdata = {16'h0, capture_first};
        OFS_CAP1: next_rdata = {16'h0, capture_second};
        OFS_PAIR_CTL: next_rdata = pair_ctl;
        OFS_PAIR_ST: next_rdata = {31'h0, count_run};
        OFS_PAIR_ICTL: next_rdata = pair_ictl;
        OFS_PAIR_OCTL: next_rdata = pair_octl;
        OFS_PAIR_CMP2: next_rdata = {16'h0, pair_cmp2};
        OFS_PAIR_CMP3: next_rdata = {16'h0, pair_cmp3};
        OFS_PAIR_PER: next_rdata = {16'h0, pair_per};
        OFS_EMG_CTL: next_rdata = emg_ctl;
        OFS_PAIR_TRG: next_rdata = pair_trg;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end
endmodule

// file: tb/mpt_channel_props.sv
`timescale 1ns/1ns
// ==========================================================
// Port checks for the timer channel
module mpt_channel_props
  import mpt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic debug_halt_i,
  input wire logic ext_clk_i,
  input wire logic capture_pin_i,
  input wire logic timer_output_pin_o,
  input wire logic first_pair_output_o,
  input wire logic second_pair_output_o,
  input wire logic overflow_irq_o,
  input wire logic first_match_irq_o,
  input wire logic second_match_irq_o,
  input wire logic first_capture_irq_o,
  input wire logic second_capture_irq_o
);
  logic gate_q;
  logic mode_q;
  // ==========================================================
  // Shadow of the enable register, which is never gated
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_q <= 1'b0;
      mode_q <= 1'b0;
    end else if (wr_i && addr_i == OFS_ENABLE) begin
      gate_q <= wdata_i[EN_GATE_BIT];
      mode_q <= wdata_i[EN_MODE_BIT];
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence en_write;
    wr_i && addr_i == OFS_ENABLE;
  endsequence
  sequence en_read;
    rd_i && addr_i == OFS_ENABLE;
  endsequence
  chk_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h00000000)
    else $error("read data not zero outside a read");
  chk_enable_read_back: assert property (en_write ##2 en_read |=>
    rdata_o == ($past(wdata_i, 3) & 32'h000000C1))
    else $error("enable register read back wrong");
  chk_capture_upper_zero: assert property (
    rd_i && (addr_i == OFS_CAP0 || addr_i == OFS_CAP1) |=> rdata_o[31:16] == 16'h0000)
    else $error("capture upper half not zero");
  chk_gate_blocks_read: assert property (
    rd_i && !gate_q && addr_i != OFS_ENABLE |=> rdata_o == 32'h00000000)
    else $error("gated register readable");
  chk_pair_pin_low: assert property (mode_q && $past(mode_q, 2) |-> !timer_output_pin_o)
    else $error("timer pin active in pair mode");
  chk_swcap_raises_irq: assert property (gate_q && !debug_halt_i && wr_i &&
    addr_i == OFS_MODE && !wdata_i[MODE_SWCAP_BIT] |-> ##[1:4] first_capture_irq_o)
    else $error("software capture gave no capture pulse");
  chk_ovf_one_pulse: assert property (overflow_irq_o |=> !overflow_irq_o)
    else $error("overflow pulse too long");
  chk_match_one_pulse: assert property ($rose(first_match_irq_o) |=> $fell(first_match_irq_o))
    else $error("match pulse too long");
  chk_capture_one_pulse: assert property (second_capture_irq_o |=> !second_capture_irq_o)
    else $error("capture pulse too long");
  chk_second_pair_idle: assert property (!debug_halt_i [*2] |-> !second_pair_output_o)
    else $error("second pair output active without halt");
endmodule

bind mpt_channel mpt_channel_props u_mpt_channel_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .debug_halt_i(debug_halt_i),
  .ext_clk_i(ext_clk_i), .capture_pin_i(capture_pin_i),
  .timer_output_pin_o(timer_output_pin_o), .first_pair_output_o(first_pair_output_o),
  .second_pair_output_o(second_pair_output_o), .overflow_irq_o(overflow_irq_o),
  .first_match_irq_o(first_match_irq_o), .second_match_irq_o(second_match_irq_o),
  .first_capture_irq_o(first_capture_irq_o), .second_capture_irq_o(second_capture_irq_o)
);

// file: tb/mpt_channel_tb.sv
`timescale 1ns/1ns
module mpt_channel_tb;
  import mpt_pkg::*;
  logic clk_sys_i, rst_n_i, wr_i, rd_i, debug_halt_i, ext_clk_i, capture_pin_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, a, b;
  logic timer_output_pin_o, first_pair_output_o, second_pair_output_o;
  logic overflow_irq_o, first_match_irq_o, second_match_irq_o;
  logic first_capture_irq_o, second_capture_irq_o;
  int err_total, checks_done, cyc, n_ov, n_c0, n_c1;
  int q_m0[$];
  int q_m1[$];

  mpt_channel u_mpt_channel (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .debug_halt_i(debug_halt_i),
    .ext_clk_i(ext_clk_i), .capture_pin_i(capture_pin_i),
    .timer_output_pin_o(timer_output_pin_o), .first_pair_output_o(first_pair_output_o),
    .second_pair_output_o(second_pair_output_o), .overflow_irq_o(overflow_irq_o),
    .first_match_irq_o(first_match_irq_o), .second_match_irq_o(second_match_irq_o),
    .first_capture_irq_o(first_capture_irq_o), .second_capture_irq_o(second_capture_irq_o)
  );
  // ==========================================================
  // Clock and event log; the overflow run dominates the ceiling
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (first_match_irq_o === 1'b1) q_m0.push_back(cyc);
    if (second_match_irq_o === 1'b1) q_m1.push_back(cyc);
    if (overflow_irq_o === 1'b1) n_ov++;
    if (first_capture_irq_o === 1'b1) n_c0++;
    if (second_capture_irq_o === 1'b1) n_c1++;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================
  // Bus and compare helpers
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    rd(ad, d);
    chk(nm, exp, d);
  endtask
  task automatic wait_m1(input int n);
    for (int i = 0; i < 300 && q_m1.size() < n; i++) @(posedge clk_sys_i);
  endtask
  // Waits until a match pulse is seen settled after an edge
  task automatic wait_irq(input logic sel);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_sys_i);
      #1;
      if ((sel ? second_match_irq_o : first_match_irq_o) === 1'b1) break;
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rchk("enable", OFS_ENABLE, 32'h0);
    rchk("gated cmp1", OFS_CMP1, 32'h0);
    wr(OFS_ENABLE, 32'h80);
    rchk("enable", OFS_ENABLE, 32'h80);
    rchk("run", OFS_RUN, 32'h0);
    rchk("mode", OFS_MODE, {25'h0, MODE_RST});
    rchk("cap0", OFS_CAP0, 32'h0);
    rchk("cap1", OFS_CAP1, 32'h0);
    rchk("unmapped", 8'h60, 32'h0);
  endtask
  task automatic t_gate();
    wr(OFS_CMP0, 32'h1234);
    wr(OFS_ENABLE, 32'h0);
    wr(OFS_CMP0, 32'h5555);
    rchk("cmp0 gated", OFS_CMP0, 32'h0);
    wr(OFS_ENABLE, 32'h80);
    rchk("cmp0 kept", OFS_CMP0, 32'h1234);
  endtask
  // Old pair 3/8 runs one period, then the buffered pair 2/10 takes over
  task automatic t_buffer();
    wr(OFS_CMP0, 32'h3);
    wr(OFS_CMP1, 32'h8);
    wr(OFS_MODE, 32'h64);
    wr(OFS_CMP0, 32'h2);
    wr(OFS_CMP1, 32'hA);
    rchk("cmp1 buffer", OFS_CMP1, 32'hA);
    q_m0.delete();
    q_m1.delete();
    wr(OFS_RUN, 32'h5);
    wait_m1(3);
    wr(OFS_RUN, 32'h4);
    chk("first gap", 32'h5, 32'(q_m1[0] - q_m0[0]));
    chk("second gap", 32'h8, 32'(q_m1[1] - q_m0[1]));
    chk("period", 32'hB, 32'(q_m1[2] - q_m1[1]));
  endtask
  task automatic t_live();
    int c0;
    wr(OFS_MODE, 32'h20);
    wr(OFS_RUN, 32'h5);
    rd(OFS_LIVE, a);
    rd(OFS_LIVE, b);
    chk("live step", 32'h2, b - a);
    wr(OFS_RUN, 32'h4);
    rchk("live held", OFS_LIVE, b);
    c0 = n_c0;
    wr(OFS_RUN, 32'h5);
    wr(OFS_MODE, 32'h0);
    wr(OFS_RUN, 32'h4);
    wr(OFS_MODE, 32'h20);
    wr(OFS_MODE, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    chk("sw captures", 32'h2, 32'(n_c0 - c0));
    rchk("cap0 cleared", OFS_CAP0, 32'h0);
    wr(OFS_MODE, 32'h20);
  endtask
  task automatic t_capture();
    int c1;
    c1 = n_c1;
    wr(OFS_MODE, 32'h30);
    wr(OFS_RUN, 32'h5);
    capture_pin_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    capture_pin_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rd(OFS_CAP0, a);
    rd(OFS_CAP1, b);
    chk("pin width", 32'hA, b - a);
    chk("cap1 pulses", 32'h1, 32'(n_c1 - c1));
    wr(OFS_RUN, 32'h4);
    wr(OFS_MODE, 32'h38);
    wr(OFS_RUN, 32'h5);
    repeat (20) @(posedge clk_sys_i);
    wr(OFS_RUN, 32'h4);
    rd(OFS_CAP0, a);
    rd(OFS_CAP1, b);
    chk("match capture", 32'h8, b - a);
  endtask
  task automatic t_flop();
    wr(OFS_FFCTL, {30'h0, FF_SET});
    repeat (3) @(posedge clk_sys_i);
    chk("flop set", 32'h1, {31'h0, timer_output_pin_o});
    wr(OFS_FFCTL, {30'h0, FF_CLEAR});
    repeat (3) @(posedge clk_sys_i);
    chk("flop clear", 32'h0, {31'h0, timer_output_pin_o});
    wr(OFS_MODE, 32'h24);
    wr(OFS_FFCTL, 32'h8);
    q_m1.delete();
    wr(OFS_RUN, 32'h5);
    wait_m1(3);
    wr(OFS_RUN, 32'h4);
    chk("flop toggles", 32'h1, {31'h0, timer_output_pin_o});
    wr(OFS_FFCTL, 32'h3);
  endtask
  task automatic t_pair();
    wr(OFS_ENABLE, 32'h81);
    wr(OFS_PAIR_PER, 32'hA);
    wr(OFS_RUN, 32'h5);
    wait_irq(1'b0);
    chk("pair active", 32'h1, {31'h0, first_pair_output_o});
    wait_irq(1'b1);
    chk("pair inactive", 32'h0, {31'h0, first_pair_output_o});
    wr(OFS_RUN, 32'h4);
    wr(OFS_ENABLE, 32'h80);
  endtask
  // Quarter tap, pin clock, then a debug halt that freezes the count in pair mode
  task automatic t_halt();
    wr(OFS_MODE, 32'h21);
    wr(OFS_RUN, 32'h5);
    rd(OFS_LIVE, a);
    repeat (14) @(posedge clk_sys_i);
    rd(OFS_LIVE, b);
    chk("quarter ticks", 32'h4, b - a);
    wr(OFS_MODE, 32'h23);
    rd(OFS_LIVE, a);
    repeat (6) @(posedge clk_sys_i) ext_clk_i <= ~ext_clk_i;
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_LIVE, b);
    chk("pin ticks", 32'h3, b - a);
    wr(OFS_MODE, 32'h20);
    wr(OFS_EMG_CTL, 32'h2);
    wr(OFS_ENABLE, 32'hC1);
    debug_halt_i <= 1'b1;
    rd(OFS_LIVE, a);
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_LIVE, b);
    chk("halt frozen", a, b);
    chk("halt pair out", 32'h1, {31'h0, second_pair_output_o});
    @(posedge clk_sys_i) debug_halt_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk("pair out idle", 32'h0, {31'h0, second_pair_output_o});
    wr(OFS_ENABLE, 32'h80);
    wr(OFS_RUN, 32'h4);
  endtask
  task automatic t_overflow();
    wr(OFS_MODE, 32'h20);
    rd(OFS_STATUS, a);
    n_ov = 0;
    wr(OFS_RUN, 32'h5);
    for (int i = 0; i < 66000 && n_ov == 0; i++) @(posedge clk_sys_i);
    wr(OFS_RUN, 32'h4);
    chk("overflows", 32'h1, 32'(n_ov));
    rd(OFS_STATUS, a);
    chk("ovf status", 32'h4, a & 32'h4);
    rd(OFS_STATUS, a);
    chk("ovf status cleared", 32'h0, a & 32'h4);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    debug_halt_i = 1'b0;
    ext_clk_i = 1'b0;
    capture_pin_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_gate();
    t_buffer();
    t_live();
    t_capture();
    t_flop();
    t_pair();
    t_halt();
    t_overflow();
    close_out();
  end
endmodule
